// ### hdl/dual_timer.sv
// two 8-bit timer/event counters with cascade and square-wave outputs
// ==========================================================
// Functional notes
// R1: two independent 8-bit counters that may be cascaded into one 16-bit.
// R2: each channel times intervals, counts external events or makes a wave.
// R3: interval equals compare value plus one times the count clock period.
// R4: in cascade the count clock comes from the low nibble of clock select.
// R5: in cascade channel a compare is the low byte and channel b the high.
// R6: software stops the timer before switching between 8 and 16 bit modes.
// R7: in cascade channel a count enable starts and stops the whole counter.
// R8: software writes output control only while the timer is stopped.
// R9: level set and level reset bits always read back as zero.
// R10: in square-wave mode the output inverts on every compare match.
// R11: software makes the pin an output and clears its port latch.
// R12: each channel requests an interrupt on match, b on its own vector.
// R13: a set mask bit blocks the match request, a clear one passes it.
// R14: after a match the counter clears on the next count clock and runs on.
// R15: clearing count enable stops and clears the counter; restart from zero.
`timescale 1ns/1ps
`include "dual_timer_map.svh"
module dual_timer
	import dual_timer_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic event_in,
	input wire logic [7:0] count_clock_select,
	input wire logic [7:0] timer_mode_control,
	input wire logic [7:0] timer_output_control,
	input wire logic timer_output_control_wr,
	input wire logic [7:0] compare_low_channel,
	input wire logic [7:0] compare_high_channel,
	input wire logic chan_a_irq_mask,
	input wire logic chan_b_irq_mask,
	output logic [7:0] timer_output_control_rd,
	output logic [7:0] count_a,
	output logic [7:0] count_b,
	output logic chan_a_wave_out,
	output logic chan_b_wave_out,
	output logic chan_a_match_irq,
	output logic chan_b_match_irq
);
	// ==========================================================
	// count clock selection
	tick_if ticks ();

	tick_prescaler u_presc
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.event_in(event_in),
		.ticks(ticks)
	);

	// code 0 counts external events, code n counts core_clk / 2^n
	function automatic logic pick_tick(input clksel_t sel,
		input logic [14:0] taps, input logic ext);
		logic r;
		r = 1'b0;
		if (sel == `CKSEL_EXT_CODE)
			r = ext;
		else
			r = taps[sel - 4'h1];
		return r;
	endfunction : pick_tick

	logic cascade;
	logic ce_a;
	logic ce_b;
	logic tick_a;
	logic tick_b;
	logic run_a;
	logic run_b;

	assign cascade = timer_mode_control[`MODE_CASCADE_BIT];
	assign ce_a = timer_mode_control[`MODE_CE_A_BIT];
	assign ce_b = timer_mode_control[`MODE_CE_B_BIT];
	assign tick_a = pick_tick(count_clock_select[`CKSEL_A_LSB +: 4],
		ticks.taps, ticks.ext_edge); // R2 R4
	assign tick_b = cascade ? tick_a :
		pick_tick(count_clock_select[`CKSEL_B_LSB +: 4],
		ticks.taps, ticks.ext_edge); // R4
	assign run_a = ce_a; // R7
	assign run_b = cascade ? ce_a : ce_b; // R7 R1

	// ==========================================================
	// counters
	logic [7:0] cnt_a_r;
	logic [7:0] cnt_b_r;
	logic [15:0] cnt16;
	logic [15:0] cmp16;
	logic match_a;
	logic match_b;
	logic pend_a_r;
	logic pend_b_r;

	assign cnt16 = {cnt_b_r, cnt_a_r};
	assign cmp16 = {compare_high_channel, compare_low_channel}; // R5
	assign match_a = cascade ? (cnt16 == cmp16) :
		(cnt_a_r == compare_low_channel);
	assign match_b = cascade ? 1'b0 : (cnt_b_r == compare_high_channel);

	// a match is seen in the cycle after the tick that reaches the compare value; the
	// counter then clears on the following tick so the period is N+1 ticks
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_a_r <= 8'h00;
			pend_a_r <= 1'b0;
		end
		else if (!run_a)
		begin
			cnt_a_r <= 8'h00; // R15
			pend_a_r <= 1'b0;
		end
		else if (tick_a)
		begin
			if (pend_a_r)
			begin
				cnt_a_r <= 8'h00; // R14 R3
				pend_a_r <= 1'b0;
			end
			else
				cnt_a_r <= cnt_a_r + 8'h01;
		end
		else if (match_a && !pend_a_r)
			pend_a_r <= 1'b1;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_b_r <= 8'h00;
			pend_b_r <= 1'b0;
		end
		else if (!run_b)
		begin
			cnt_b_r <= 8'h00; // R15
			pend_b_r <= 1'b0;
		end
		else if (cascade)
		begin
			pend_b_r <= 1'b0;
			if (tick_a && pend_a_r)
				cnt_b_r <= 8'h00; // R14
			else if (tick_a && cnt_a_r == 8'hFF)
				cnt_b_r <= cnt_b_r + 8'h01; // R1
		end
		else if (tick_b)
		begin
			if (pend_b_r)
			begin
				cnt_b_r <= 8'h00; // R14 R3
				pend_b_r <= 1'b0;
			end
			else
				cnt_b_r <= cnt_b_r + 8'h01;
		end
		else if (match_b && !pend_b_r)
			pend_b_r <= 1'b1;
	end

	// one-cycle match events, taken when the pending flag rises
	logic hit_a;
	logic hit_b;
	assign hit_a = run_a && !tick_a && match_a && !pend_a_r;
	assign hit_b = run_b && !cascade && !tick_b && match_b && !pend_b_r;

	// ==========================================================
	// interrupts
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			chan_a_match_irq <= 1'b0;
			chan_b_match_irq <= 1'b0;
		end
		else
		begin
			chan_a_match_irq <= hit_a && !chan_a_irq_mask; // R12 R13
			// in cascade the combined match is reported on channel b
			chan_b_match_irq <= (cascade ? hit_a : hit_b)
				&& !chan_b_irq_mask; // R12 R13
		end
	end

	// ==========================================================
	// timer outputs
	logic sqw_a;
	logic sqw_b;
	logic oe_a;
	logic oe_b;
	logic tog_a_r;
	logic tog_b_r;
	assign oe_a = timer_output_control[`OUTC_OE_A_BIT];
	assign oe_b = timer_output_control[`OUTC_OE_B_BIT];
	assign sqw_a = timer_output_control[`OUTC_SQW_A_BIT];
	assign sqw_b = timer_output_control[`OUTC_SQW_B_BIT];

	// level set/reset act only on the write strobe, so they are one-shot
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			tog_a_r <= 1'b0;
		else if (timer_output_control_wr
			&& timer_output_control[`OUTC_LVS_A_BIT])
			tog_a_r <= 1'b1;
		else if (timer_output_control_wr
			&& timer_output_control[`OUTC_LVR_A_BIT])
			tog_a_r <= 1'b0;
		else if (hit_a && sqw_a)
			tog_a_r <= ~tog_a_r; // R10
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			tog_b_r <= 1'b0;
		else if (timer_output_control_wr
			&& timer_output_control[`OUTC_LVS_B_BIT])
			tog_b_r <= 1'b1;
		else if (timer_output_control_wr
			&& timer_output_control[`OUTC_LVR_B_BIT])
			tog_b_r <= 1'b0;
		else if ((cascade ? hit_a : hit_b) && sqw_b)
			tog_b_r <= ~tog_b_r; // R10
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			chan_a_wave_out <= 1'b0;
			chan_b_wave_out <= 1'b0;
			timer_output_control_rd <= `OUTC_RESET;
			count_a <= 8'h00;
			count_b <= 8'h00;
		end
		else
		begin
			chan_a_wave_out <= oe_a & tog_a_r;
			chan_b_wave_out <= oe_b & tog_b_r;
			timer_output_control_rd <= timer_output_control
				& `OUTC_RO_MASK; // R9
			count_a <= cnt_a_r;
			count_b <= cnt_b_r;
		end
	end

	// ==========================================================
	// checks
	sequence s_hit_a;
		hit_a;
	endsequence

	chk_irq_a_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
		chan_a_irq_mask |=> !chan_a_match_irq) // R13
		else $error("masked channel a irq fired");
	chk_irq_a_follows: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		s_hit_a ##0 !chan_a_irq_mask |=> chan_a_match_irq) // R12
		else $error("channel a match gave no irq");
	chk_stop_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
		!run_a |=> cnt_a_r == 8'h00) // R15
		else $error("stopped counter not cleared");
	chk_clear_after_match: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		run_a && tick_a && pend_a_r ##1 run_a |-> cnt_a_r == 8'h00) // R14
		else $error("counter did not clear after match");
	chk_toggle_on_match: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		hit_a && sqw_a && !timer_output_control_wr
		|=> tog_a_r != $past(tog_a_r)) // R10
		else $error("square wave did not toggle");
	chk_level_readzero: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		##1 (timer_output_control_rd & ~`OUTC_RO_MASK) == 8'h00) // R9
		else $error("level bits read nonzero");
	chk_cascade_enable: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		cascade && !ce_a |=> cnt_b_r == 8'h00) // R7
		else $error("cascade ran with chan a disabled");
	chk_cascade_carry: assert property (@(posedge core_clk)
		disable iff (!rst_n)
		cascade && run_a && tick_a && !pend_a_r && cnt_a_r == 8'hFF
		|=> cnt_b_r == $past(cnt_b_r) + 8'h01) // R1 R5
		else $error("cascade carry missing");
	chk_count_step: assert property (@(posedge core_clk) disable iff (!rst_n)
		run_a && tick_a && !pend_a_r ##1 run_a
		|-> cnt_a_r == $past(cnt_a_r) + 8'h01) // R3 R4
		else $error("counter did not step on tick");
endmodule : dual_timer

// ### hdl/dual_timer_map.svh
// register field positions, reset values and prescaler figures for the timer
`ifndef DUAL_TIMER_MAP_SVH
`define DUAL_TIMER_MAP_SVH
// count_clock_select: low nibble chan a / cascade, high nibble chan b
`define CKSEL_A_LSB 0
`define CKSEL_B_LSB 4
`define CKSEL_EXT_CODE 4'h0
// timer_mode_control bits
`define MODE_CE_A_BIT 0
`define MODE_CE_B_BIT 1
`define MODE_CASCADE_BIT 2
// timer_output_control bits
`define OUTC_OE_A_BIT 0
`define OUTC_SQW_A_BIT 1
`define OUTC_LVR_A_BIT 2
`define OUTC_LVS_A_BIT 3
`define OUTC_OE_B_BIT 4
`define OUTC_SQW_B_BIT 5
`define OUTC_LVR_B_BIT 6
`define OUTC_LVS_B_BIT 7
`define OUTC_RO_MASK 8'h33
`define CKSEL_RESET 8'h00
`define MODE_RESET 8'h00
`define OUTC_RESET 8'h00
`define CMP_RESET 8'h00
// prescaler taps: code n (1..15) selects core_clk / 2^n
`define PRESC_WIDTH 15
`define SEL_WIDTH 4
`endif

// ### hdl/dual_timer_pkg.sv
// types shared by the dual timer modules
package dual_timer_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [3:0] clksel_t;
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_MATCH = 2'b11
	} chan_state_e;
endpackage : dual_timer_pkg

// ### hdl/tick_if.sv
// count-clock ticks passed from the prescaler to the channels
`timescale 1ns/1ps
interface tick_if;
	logic [14:0] taps;
	logic ext_edge;
	modport src (output taps, output ext_edge);
	modport dst (input taps, input ext_edge);
endinterface : tick_if

// ### hdl/tick_prescaler.sv
// free-running prescaler and external event edge detector
`timescale 1ns/1ps
`include "dual_timer_map.svh"
module tick_prescaler
	import dual_timer_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic event_in,
	tick_if.src ticks
);
	logic [`PRESC_WIDTH-1:0] div_r;
	logic [`PRESC_WIDTH-1:0] div_nxt;
	logic [`PRESC_WIDTH-1:0] taps_r;
	logic ev_s1_r;
	logic ev_s2_r;
	logic ev_s3_r;
	logic edge_r;

	assign div_nxt = div_r + `PRESC_WIDTH'(1);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			div_r <= '0;
		else
			div_r <= div_nxt;
	end

	// tap n pulses once per 2^(n+1) cycles, one cycle long
	genvar g;
	generate
		for (g = 0; g < `PRESC_WIDTH; g++)
		begin : g_tap
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
					taps_r[g] <= 1'b0;
				else
					taps_r[g] <= &div_nxt[g:0];
			end
		end
	endgenerate

	// pin is asynchronous: two stages before the edge detector
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ev_s1_r <= 1'b0;
			ev_s2_r <= 1'b0;
			ev_s3_r <= 1'b0;
			edge_r <= 1'b0;
		end
		else
		begin
			ev_s1_r <= event_in;
			ev_s2_r <= ev_s1_r;
			ev_s3_r <= ev_s2_r;
			edge_r <= ev_s2_r & ~ev_s3_r;
		end
	end

	assign ticks.taps = taps_r;
	assign ticks.ext_edge = edge_r;
endmodule : tick_prescaler

// ### tb/event_src.sv
// external event source and timer output pin load
`timescale 1ns/1ps
module event_src
(
	input wire logic core_clk,
	input wire logic start,
	input wire logic [7:0] num,
	input wire logic wave,
	output logic event_in,
	output logic done,
	output logic [15:0] toggles
);
	logic [7:0] left_r = 8'h00;
	logic [2:0] ph_r = 3'h0;
	logic wave_r = 1'b0;
	logic ev_r = 1'b0;
	logic done_r = 1'b1;
	logic [15:0] tog_r = 16'h0000;
	assign event_in = ev_r;
	assign done = done_r;
	assign toggles = tog_r;
	// ==========================================================
	// event pulses
	// each level lasts 4 clocks, since the pin is synchronised inside
	always @(posedge core_clk)
	begin
		if (start)
		begin
			left_r <= num;
			done_r <= 1'b0;
			ph_r <= 3'h0;
		end
		else if (left_r != 8'h00)
		begin
			ph_r <= ph_r + 3'h1;
			ev_r <= (ph_r < 3'h4);
			if (ph_r == 3'h7)
				left_r <= left_r - 8'h01;
		end
		else
		begin
			ev_r <= 1'b0;
			done_r <= 1'b1;
		end
	end
	// ==========================================================
	// pin load counts every edge of the wave
	always @(posedge core_clk)
	begin
		wave_r <= wave;
		if (wave !== wave_r)
			tog_r <= tog_r + 16'h0001;
	end
endmodule : event_src

// ### tb/tb.sv
// self-checking testbench for the dual timer
`timescale 1ns/1ps
module tb;
	import dual_timer_pkg::*;
	logic core_clk = 0;
	logic rst_n = 0;
	logic ev_go = 0;
	logic [7:0] ev_num = 8'h00;
	logic event_in, ev_done, outc_wr = 0;
	logic [7:0] cksel = 8'h00, mode = 8'h00, outc = 8'h00;
	logic [7:0] cmp_lo = 8'h00, cmp_hi = 8'h00;
	logic mask_a = 0, mask_b = 0;
	byte_t outc_rd, cnt_a, cnt_b;
	logic wave_a, wave_b, irq_a, irq_b, w;
	logic [15:0] tg, big;
	int errors = 0, checks = 0, cyc, n, sa, sb, na, nb, i;
	always #4 core_clk = ~core_clk;
	dual_timer dual_timer_inst (.core_clk(core_clk), .rst_n(rst_n),
		.event_in(event_in), .count_clock_select(cksel),
		.timer_mode_control(mode), .timer_output_control(outc),
		.timer_output_control_wr(outc_wr), .compare_low_channel(cmp_lo),
		.compare_high_channel(cmp_hi), .chan_a_irq_mask(mask_a),
		.chan_b_irq_mask(mask_b), .timer_output_control_rd(outc_rd),
		.count_a(cnt_a), .count_b(cnt_b), .chan_a_wave_out(wave_a),
		.chan_b_wave_out(wave_b), .chan_a_match_irq(irq_a),
		.chan_b_match_irq(irq_b));
	event_src event_src_inst (.core_clk(core_clk), .start(ev_go),
		.num(ev_num), .wave(wave_a), .event_in(event_in), .done(ev_done),
		.toggles(tg));
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task wrap_up;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up
	task clocks(input int k);
		repeat (k) @(negedge core_clk);
	endtask : clocks
	// cycles between two consecutive match pulses of one channel
	task period(input bit b, output int c);
		c = 0;
		while ((b ? irq_b : irq_a) !== 1'b1 && c < 4000)
		begin
			clocks(1);
			c++;
		end
		c = 0;
		do
		begin
			clocks(1);
			c++;
		end
		while ((b ? irq_b : irq_a) !== 1'b1 && c < 4000);
	endtask : period
	// output control is only written with the timer stopped
	task set_outc(input logic [7:0] v);
		mode = 8'h00;
		outc = v;
		outc_wr = 1;
		clocks(1);
		outc_wr = 0;
		clocks(1);
	endtask : set_outc
	initial
	begin
		#600000;
		errors++;
		wrap_up();
	end
	initial
	begin
		n = $urandom(63);
		clocks(6);
		rst_n = 1;
		clocks(1);
		check({outc_rd, cnt_a}, 16'h0000);
		for (i = 0; i < 4; i++)
		begin
			set_outc(8'($urandom));
			check(outc_rd, outc & 8'h33);
		end
		set_outc(8'h00);
		for (i = 0; i < 3; i++)
		begin
			mode = 8'h00;
			clocks(1);
			sa = $urandom_range(3, 1);
			sb = $urandom_range(3, 1);
			na = $urandom_range(40, 1);
			nb = (i == 0) ? 0 : $urandom_range(40, 1);
			cksel = {sb[3:0], sa[3:0]};
			cmp_lo = na[7:0];
			cmp_hi = nb[7:0];
			mode = 8'h03;
			period(0, cyc);
			check(16'(cyc), 16'((na + 1) << sa));
			period(1, cyc);
			check(16'(cyc), 16'((nb + 1) << sb));
		end
		mode = 8'h00;
		clocks(2);
		check({cnt_b, cnt_a}, 16'h0000);
		clocks(3);
		check({cnt_b, cnt_a}, 16'h0000);
		set_outc(8'h03);
		cksel = 8'h01;
		cmp_lo = 8'h04;
		mode = 8'h01;
		period(0, cyc);
		w = wave_a;
		n = tg;
		period(0, cyc);
		check(wave_a, !w);
		check(tg - n[15:0], 16'h0001);
		check(16'(cyc), 16'h000A);
		mask_a = 1;
		n = 0;
		repeat (100)
		begin
			clocks(1);
			n += irq_a;
		end
		check(16'(n), 16'h0000);
		mask_a = 0;
		// level set and reset drive channel b pin while stopped
		set_outc(8'h90);
		check(wave_b, 1'b1);
		check(outc_rd, 8'h10);
		set_outc(8'h50);
		check(wave_b, 1'b0);
		check(outc_rd, 8'h10);
		mode = 8'h00;
		clocks(1);
		big = {8'h01, 8'($urandom)};
		cksel = {4'($urandom_range(15, 4)), 4'h1};
		{cmp_hi, cmp_lo} = big;
		mode = 8'h05;
		period(0, cyc);
		check(16'(cyc), 16'((big + 1) * 2));
		check(irq_b, 1'b1);
		mask_b = 1;
		n = 0;
		sa = 0;
		repeat (1100)
		begin
			clocks(1);
			n += irq_b;
			sa += irq_a;
		end
		check(16'(n), 16'h0000);
		check(16'(sa != 0), 16'h0001);
		mask_b = 0;
		mode = 8'h06;
		clocks(3);
		check({cnt_b, cnt_a}, 16'h0000);
		mode = 8'h00;
		cksel = 8'h00;
		cmp_lo = 8'hFF;
		mode = 8'h01;
		ev_num = 8'($urandom_range(20, 3));
		ev_go = 1;
		clocks(1);
		ev_go = 0;
		n = 0;
		do
		begin
			clocks(1);
			n++;
		end
		while (ev_done !== 1'b1 && n < 1000);
		check(16'(n < 1000), 16'h0001);
		clocks(8);
		check(cnt_a, ev_num);
		wrap_up();
	end
endmodule : tb
